// file: common/vlan_map.svh
// Purpose: Constants for the port broadcast-domain membership block
// Assumes: One clock, synchronous inputs
// Notes: Domain 0 is the permanent default domain
`ifndef VLAN_MAP_SVH
`define VLAN_MAP_SVH
`define DOM_DEFAULT 3'h0
`define DOM_MAX 8
`define NAME_MAX_CHARS 12
`define CHAR_SPACE 8'h20
`define FIFO_DEPTH 8
`define MAC_RESET 48'h0000_0000_0000
`endif

// file: common/vlan_pkg.sv
// Purpose: Types for the port broadcast-domain membership block
// Assumes: Constants live in vlan_map.svh
// Notes: Port count fixed at 16 in the frame descriptor
package vlan_pkg;
  typedef logic [2:0] dom_t;
  typedef logic [15:0] pmask_t;
  typedef struct packed {
    logic [3:0] src_port;
    logic [15:0] dst_mask;
    logic [7:0] tag;
  } frame_s;
  typedef enum logic [2:0] {
    CMD_ASSIGN,
    CMD_CREATE,
    CMD_DELETE,
    CMD_RENAME,
    CMD_SET_MAC,
    CMD_MONITOR,
    CMD_RESTART
  } cmd_e;
  typedef struct packed {
    cmd_e op;
    logic [3:0] port;
    dom_t dom;
    logic flag;
    logic [47:0] mac;
    logic [95:0] name;
  } cfg_s;
endpackage

// file: logic/frame_fifo.sv
// Purpose: Buffer of frame descriptors with valid/ready on both sides
// Assumes: Single clock
// Notes: Full and empty from a count
`timescale 1ns/1ps
module frame_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff, rp_ff;
  logic [AW:0] cnt_ff;
  logic push, pop;
  assign wr_ready_out = (cnt_ff != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_ff != '0);
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;
  assign rd_data_out = mem_ff[rp_ff];
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_ff[wp_ff] <= wr_data_in;
    end
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      if (pop) rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // frame_fifo

// file: logic/port_up_mask.sv
// Purpose: Per-domain link-up reduction
// Assumes: Membership given as one domain code per port
// Notes: Purely combinational
`timescale 1ns/1ps
module port_up_mask #(
  parameter int PORTS = 16
) (
  input wire logic [PORTS*3-1:0] dom_of_port_in,
  input wire logic [PORTS-1:0] member_in,
  input wire logic [PORTS-1:0] link_up_in,
  input wire logic [2:0] dom_in,
  output logic [PORTS-1:0] same_out,
  output logic any_up_out
);
  always_comb begin
    for (int i = 0; i < PORTS; i++) begin
      same_out[i] = member_in[i] && (dom_of_port_in[i*3 +: 3] == dom_in);
    end
    any_up_out = |(same_out & link_up_in);
  end
endmodule // port_up_mask

// file: logic/port_vlan_membership.sv
// Purpose: Port-based broadcast-domain membership and forwarding mask
// Assumes: Config requests come one per cycle from a management agent
// Notes: Frame descriptors pass through an 8-entry FIFO and leave masked
// Notes on behaviour
// - Forward frames only to ports in the ingress port's domain.
// - Table holds exactly one domain code per port.
// - Unassigned ports fall into the default domain.
// - Domain interface active while any member port is up.
// - One MAC per domain interface, eight at most; reset loads all alike and CMD_SET_MAC allows duplicates.
// - Spanning tree BPDU source MAC is the domain's MAC.
// - IPX node address equals the domain interface MAC.
// - Reject assignments that split a trunk across domains.
// - Monitoring port is removed from and kept out of all domains.
// - Clearing monitoring returns the port to the default domain.
// - Ports of a newly filled slot join the default domain.
// - After reset all ports sit in the permanent default domain.
// - Default domain may be renamed but never deleted.
// - New domains usable after restart; reassignment acts at once.
// - Names up to 12 characters, no spaces.
`timescale 1ns/1ps
`include "vlan_map.svh"
module port_vlan_membership #(
  parameter int PORTS = 16,
  parameter int SLOTS = 4,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Configuration request
  input wire logic cfg_valid_in,
  input wire vlan_pkg::cfg_s cfg_in,
  output logic cfg_ack_out,
  output logic cfg_err_out,
  // Port state
  input wire logic [PORTS-1:0] link_up_in,
  input wire logic [PORTS-1:0] trunk_group_en_in,
  input wire logic [PORTS*2-1:0] trunk_group_in,
  input wire logic [SLOTS-1:0] slot_present_in,
  // Frame path
  input wire logic frm_valid_in,
  input wire vlan_pkg::frame_s frm_in,
  output logic frm_ready_out,
  output logic frm_valid_out,
  output vlan_pkg::frame_s frm_out,
  input wire logic frm_ready_in,
  // Per-domain status and per-port monitor mask
  input wire vlan_pkg::dom_t mac_sel_in,
  output logic [47:0] bpdu_src_mac_out,
  output logic [47:0] ipx_node_out,
  output logic [`DOM_MAX-1:0] dom_active_out,
  output logic [`DOM_MAX-1:0] dom_usable_out,
  output logic [PORTS-1:0] monitor_mask_out
);
  localparam int PPS = PORTS / SLOTS;
  // ===================================================
  // Tables
  // ===================================================
  vlan_pkg::dom_t dom_of_ff [PORTS];
  logic [PORTS-1:0] member_ff;
  logic [PORTS-1:0] monitor_ff;
  logic [`DOM_MAX-1:0] dom_created_ff, dom_usable_ff;
  logic [47:0] mac_ff [`DOM_MAX];
  logic [95:0] name_ff [`DOM_MAX];
  logic [SLOTS-1:0] slot_seen_ff;
  logic [PORTS*3-1:0] dom_flat;
  always_comb begin
    for (int i = 0; i < PORTS; i++) begin
      dom_flat[i*3 +: 3] = dom_of_ff[i];
    end
  end
  // ===================================================
  // Request checks
  // ===================================================
  logic name_ok, trunk_ok, dom_empty, req_ok;
  logic [1:0] grp;
  logic grp_en;
  always_comb begin
    name_ok = 1'b1;
    for (int c = 0; c < `NAME_MAX_CHARS; c++) begin
      if (cfg_in.name[c*8 +: 8] == `CHAR_SPACE) name_ok = 1'b0;
    end
    if (cfg_in.name[7:0] == 8'h00) name_ok = 1'b0;
  end
  // A trunk member may be assigned only if every other unmonitored member of its group already sits in the target
  always_comb begin
    grp = trunk_group_in[cfg_in.port*2 +: 2];
    grp_en = trunk_group_en_in[cfg_in.port];
    trunk_ok = 1'b1;
    for (int i = 0; i < PORTS; i++) begin
      if (grp_en && trunk_group_en_in[i] && trunk_group_in[i*2 +: 2] == grp && i != int'(cfg_in.port)
          && member_ff[i] && dom_of_ff[i] != cfg_in.dom) trunk_ok = 1'b0;
    end
  end
  always_comb begin
    dom_empty = 1'b1;
    for (int i = 0; i < PORTS; i++) begin
      if (member_ff[i] && dom_of_ff[i] == cfg_in.dom) dom_empty = 1'b0;
    end
  end
  always_comb begin
    req_ok = 1'b0;
    case (cfg_in.op)
      vlan_pkg::CMD_ASSIGN: req_ok = dom_usable_ff[cfg_in.dom] && !monitor_ff[cfg_in.port]
                                     && trunk_ok;
      vlan_pkg::CMD_CREATE: req_ok = !dom_created_ff[cfg_in.dom] && name_ok;
      vlan_pkg::CMD_DELETE: req_ok = cfg_in.dom != `DOM_DEFAULT && dom_created_ff[cfg_in.dom]
                                     && dom_empty;
      vlan_pkg::CMD_RENAME: req_ok = dom_created_ff[cfg_in.dom] && name_ok;
      vlan_pkg::CMD_SET_MAC: req_ok = 1'b1;
      vlan_pkg::CMD_MONITOR: req_ok = 1'b1;
      vlan_pkg::CMD_RESTART: req_ok = 1'b1;
      default: req_ok = 1'b0;
    endcase
  end
  logic do_req;
  assign do_req = cfg_valid_in && req_ok;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_ack_out <= 1'b0;
      cfg_err_out <= 1'b0;
    end else begin
      cfg_ack_out <= cfg_valid_in && req_ok;
      cfg_err_out <= cfg_valid_in && !req_ok;
    end
  end
  // ===================================================
  // Domain table
  // ===================================================
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dom_created_ff <= `DOM_MAX'(1);
      dom_usable_ff <= `DOM_MAX'(1);
    end else if (do_req) begin
      case (cfg_in.op)
        vlan_pkg::CMD_CREATE: dom_created_ff[cfg_in.dom] <= 1'b1;
        vlan_pkg::CMD_DELETE: begin
          dom_created_ff[cfg_in.dom] <= 1'b0;
          dom_usable_ff[cfg_in.dom] <= 1'b0;
        end
        vlan_pkg::CMD_RESTART: dom_usable_ff <= dom_created_ff;
        default: ;
      endcase
    end
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int d = 0; d < `DOM_MAX; d++) begin
        mac_ff[d] <= `MAC_RESET;
        name_ff[d] <= '0;
      end
    end else if (do_req) begin
      if (cfg_in.op == vlan_pkg::CMD_SET_MAC) mac_ff[cfg_in.dom] <= cfg_in.mac;
      if (cfg_in.op == vlan_pkg::CMD_CREATE || cfg_in.op == vlan_pkg::CMD_RENAME) begin
        name_ff[cfg_in.dom] <= cfg_in.name;
      end
    end
  end
  // ===================================================
  // Port membership
  // ===================================================
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < PORTS; i++) dom_of_ff[i] <= `DOM_DEFAULT;
      member_ff <= '1;
      monitor_ff <= '0;
      slot_seen_ff <= '1;
    end else begin
      slot_seen_ff <= slot_present_in;
      for (int s = 0; s < SLOTS; s++) begin
        if (slot_present_in[s] && !slot_seen_ff[s]) begin
          for (int k = 0; k < PPS; k++) begin
            if (!monitor_ff[s*PPS+k]) begin
              dom_of_ff[s*PPS+k] <= `DOM_DEFAULT;
              member_ff[s*PPS+k] <= 1'b1;
            end
          end
        end
      end
      if (do_req && cfg_in.op == vlan_pkg::CMD_ASSIGN) begin
        dom_of_ff[cfg_in.port] <= cfg_in.dom;
      end
      if (do_req && cfg_in.op == vlan_pkg::CMD_MONITOR) begin
        monitor_ff[cfg_in.port] <= cfg_in.flag;
        member_ff[cfg_in.port] <= !cfg_in.flag;
        if (!cfg_in.flag) dom_of_ff[cfg_in.port] <= `DOM_DEFAULT;
      end
    end
  end
  // ===================================================
  // Interface state
  // ===================================================
  logic [`DOM_MAX-1:0] nxt_active;
  for (genvar d = 0; d < `DOM_MAX; d++) begin : g_dom
    port_up_mask #(.PORTS(PORTS)) u_up (
      .dom_of_port_in(dom_flat),
      .member_in(member_ff),
      .link_up_in(link_up_in),
      .dom_in(3'(d)),
      .same_out(),
      .any_up_out(nxt_active[d])
    );
  end
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dom_active_out <= '0;
      bpdu_src_mac_out <= `MAC_RESET;
      ipx_node_out <= `MAC_RESET;
    end else begin
      dom_active_out <= nxt_active & dom_created_ff;
      bpdu_src_mac_out <= mac_ff[mac_sel_in];
      ipx_node_out <= mac_ff[mac_sel_in];
    end
  end
  assign dom_usable_out = dom_usable_ff;
  assign monitor_mask_out = monitor_ff;
  // ===================================================
  // Frame path
  // ===================================================
  vlan_pkg::frame_s q_frm;
  logic q_valid, q_ready;
  frame_fifo #(.WIDTH($bits(vlan_pkg::frame_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_data_in(frm_in),
    .wr_valid_in(frm_valid_in),
    .wr_ready_out(frm_ready_out),
    .rd_data_out(q_frm),
    .rd_valid_out(q_valid),
    .rd_ready_in(q_ready)
  );
  logic [PORTS-1:0] same_dom;
  port_up_mask #(.PORTS(PORTS)) u_fwd (
    .dom_of_port_in(dom_flat),
    .member_in(member_ff),
    .link_up_in(link_up_in),
    .dom_in(dom_of_ff[q_frm.src_port]),
    .same_out(same_dom),
    .any_up_out()
  );
  // Output register stage; stalls when downstream holds ready low
  assign q_ready = !frm_valid_out || frm_ready_in;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      frm_valid_out <= 1'b0;
      frm_out <= '0;
    end else if (q_ready) begin
      frm_valid_out <= q_valid;
      frm_out.src_port <= q_frm.src_port;
      frm_out.tag <= q_frm.tag;
      // Monitored ingress reaches nobody, and the ingress itself is never a target
      frm_out.dst_mask <= member_ff[q_frm.src_port] ?
                          (q_frm.dst_mask & same_dom & ~(PORTS'(1) << q_frm.src_port)) : '0;
    end
  end
endmodule // port_vlan_membership

// file: testbench/vlan_properties.sv
// Purpose: Port-level checker for port_vlan_membership
// Assumes: Domain 0 is the default domain
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
`include "vlan_map.svh"
module vlan_properties #(
  parameter int PORTS = 16
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic cfg_valid_in,
  input wire vlan_pkg::cfg_s cfg_in,
  input wire logic cfg_ack_out,
  input wire logic cfg_err_out,
  input wire logic frm_valid_out,
  input wire vlan_pkg::frame_s frm_out,
  input wire logic frm_ready_in,
  input wire logic [`DOM_MAX-1:0] dom_usable_out,
  input wire logic [PORTS-1:0] monitor_mask_out
);
  // ====
  // Helpers
  logic mon_set;
  logic mon_clr;
  logic del_def;
  logic bad_name;
  assign mon_set = cfg_valid_in && cfg_in.op == vlan_pkg::CMD_MONITOR && cfg_in.flag;
  assign mon_clr = cfg_valid_in && cfg_in.op == vlan_pkg::CMD_MONITOR && !cfg_in.flag;
  assign del_def = cfg_valid_in && cfg_in.op == vlan_pkg::CMD_DELETE && cfg_in.dom == `DOM_DEFAULT;
  // Only first char checked here; embedded spaces left to the bench
  assign bad_name = cfg_valid_in && cfg_in.op == vlan_pkg::CMD_CREATE &&
    (cfg_in.name[7:0] == `CHAR_SPACE || cfg_in.name[7:0] == 8'h00);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ====
  // Assertions
  AST_ONE_ANSWER: assert property (cfg_valid_in |=> cfg_ack_out != cfg_err_out)
    else $error("request without exactly one answer");
  AST_NO_STRAY: assert property ((cfg_ack_out || cfg_err_out) |-> $past(cfg_valid_in))
    else $error("answer without request");
  AST_MON_SET: assert property (mon_set |=> cfg_ack_out && monitor_mask_out[$past(cfg_in.port)])
    else $error("monitor port not marked");
  AST_MON_CLR: assert property (mon_clr |=> !monitor_mask_out[$past(cfg_in.port)])
    else $error("monitor mark not cleared");
  AST_KEEP_DEF: assert property (del_def |=> cfg_err_out && dom_usable_out[0])
    else $error("default domain deleted");
  AST_BAD_NAME: assert property (bad_name |=> cfg_err_out)
    else $error("bad name accepted");
  AST_HOLD: assert property (frm_valid_out && !frm_ready_in |=> frm_valid_out && $stable(frm_out))
    else $error("frame changed while stalled");
  AST_NO_ECHO: assert property (frm_valid_out |-> !frm_out.dst_mask[frm_out.src_port])
    else $error("frame sent back to source");
  COV_FRM: cover property (frm_valid_out && frm_ready_in);
  COV_ERR: cover property (cfg_err_out);
  COV_MON: cover property (monitor_mask_out != '0);
endmodule // vlan_properties

bind port_vlan_membership vlan_properties #(.PORTS(PORTS)) u_props (.sys_clk_in, .sys_rst_in,
  .cfg_valid_in, .cfg_in, .cfg_ack_out, .cfg_err_out, .frm_valid_out, .frm_out, .frm_ready_in,
  .dom_usable_out, .monitor_mask_out);

// file: testbench/frame_sink.sv
// Purpose: Station model taking forwarded frame descriptors
// Assumes: Ready may stall fully or alternate
// Notes: Keeps last frame and a count
`timescale 1ns/1ps
module frame_sink (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic stall_in,
  input wire logic slow_in,
  input wire logic frm_valid_in,
  input wire vlan_pkg::frame_s frm_in,
  output logic frm_ready_out,
  output vlan_pkg::frame_s last_out,
  output logic [7:0] count_out
);
  // ====
  // Receive side
  logic phase_ff;
  assign frm_ready_out = !stall_in && (!slow_in || phase_ff);
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      phase_ff <= 1'h0;
      count_out <= 8'h00;
      last_out <= '0;
    end else begin
      phase_ff <= !phase_ff;
      // Station only sinks; no path on to another domain
      if (frm_valid_in && frm_ready_out) begin
        last_out <= frm_in;
        count_out <= count_out + 8'h01;
      end
    end
  end
endmodule // frame_sink

// file: testbench/tb_top.sv
// Purpose: Self-checking bench for port_vlan_membership
// Assumes: 50 MHz clock, reset held 5 cycles
// Notes: Config commands first, then frame rows, hand tests after
`timescale 1ns/1ps
module tb_top;
  // ====
  // Signals
  logic sys_clk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic cfg_valid_in = 1'h0;
  vlan_pkg::cfg_s cfg_in = '0;
  logic cfg_ack_out, cfg_err_out, frm_ready_out, frm_valid_out, frm_ready_in;
  logic [15:0] link_up_in = 16'hFFFF;
  logic [15:0] trunk_group_en_in = 16'h0300;
  logic [31:0] trunk_group_in = 32'h0005_0000;
  logic [3:0] slot_present_in = 4'hF;
  logic frm_valid_in = 1'h0;
  vlan_pkg::frame_s frm_in = '0;
  vlan_pkg::frame_s frm_out, last;
  vlan_pkg::dom_t mac_sel_in = 3'h0;
  logic [47:0] bpdu_src_mac_out, ipx_node_out;
  logic [7:0] dom_active_out, dom_usable_out, cnt;
  logic [15:0] monitor_mask_out;
  logic stall = 1'h0;
  logic slow = 1'h0;
  int fail_count = 0;
  int num_checks = 0;
  int taken;
  logic [15:0] rows [3][3] = '{'{16'h0, 16'hFFFF, 16'hFF0E}, '{16'h5, 16'hFFFF, 16'h00D0},
    '{16'h9, 16'h0011, 16'h0001}};
  always #10 sys_clk_in = ~sys_clk_in;
  port_vlan_membership dut (.*);
  // One sink stands for one station receiving the frames of every domain
  frame_sink sink (.sys_clk_in, .sys_rst_in, .stall_in(stall), .slow_in(slow), .frm_valid_in(frm_valid_out),
    .frm_in(frm_out), .frm_ready_out(frm_ready_in), .last_out(last), .count_out(cnt));
  // ====
  // Tasks
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input vlan_pkg::cmd_e op, input logic [3:0] p, input logic [2:0] d, input logic f,
    input logic [95:0] n, input logic e);
    @(posedge sys_clk_in);
    cfg_valid_in <= 1'h1;
    cfg_in <= '{op, p, d, f, 48'hA000_0000_0000 + d, n};
    @(posedge sys_clk_in);
    cfg_valid_in <= 1'h0;
    #1;
    chk({cfg_ack_out, cfg_err_out}, {~e, e});
  endtask
  // Waits bounded so a dead handshake shows as a mismatch
  task automatic frame(input logic [3:0] s, input logic [15:0] m, input logic [15:0] e);
    logic [7:0] c0;
    int n;
    c0 = cnt;
    @(posedge sys_clk_in);
    frm_valid_in <= 1'h1;
    frm_in <= '{s, m, 8'h5A};
    #1;
    for (n = 0; n < 50 && frm_ready_out !== 1'h1; n++) begin
      @(posedge sys_clk_in);
      #1;
    end
    @(posedge sys_clk_in);
    frm_valid_in <= 1'h0;
    for (n = 0; n < 50 && cnt == c0; n++) begin
      @(posedge sys_clk_in);
      #1;
    end
    // Count delta catches a handshake that timed out
    chk({8'(cnt - c0), last.src_port, last.tag, last.dst_mask}, {8'h01, s, 8'h5A, e});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ====
  // Sequence
  initial begin
    #(20 * 5000);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge sys_clk_in);
    sys_rst_in <= 1'h0;
    #1;
    chk({dom_usable_out, monitor_mask_out, frm_valid_out}, {8'h01, 16'h0000, 1'h0});
    cmd(vlan_pkg::CMD_ASSIGN, 4'h4, 3'h1, 1'h0, 96'h41, 1'h1);
    cmd(vlan_pkg::CMD_CREATE, 4'h0, 3'h1, 1'h0, 96'h42_2041, 1'h1);
    cmd(vlan_pkg::CMD_CREATE, 4'h0, 3'h1, 1'h0, 96'h20, 1'h1);
    cmd(vlan_pkg::CMD_CREATE, 4'h0, 3'h1, 1'h0, 96'h41, 1'h0);
    cmd(vlan_pkg::CMD_RESTART, 4'h0, 3'h0, 1'h0, 96'h0, 1'h0);
    chk(dom_usable_out, 8'h03);
    for (int p = 4; p < 8; p++) cmd(vlan_pkg::CMD_ASSIGN, 4'(p), 3'h1, 1'h0, 96'h0, 1'h0);
    cmd(vlan_pkg::CMD_ASSIGN, 4'h8, 3'h1, 1'h0, 96'h0, 1'h1);
    cmd(vlan_pkg::CMD_DELETE, 4'h0, 3'h0, 1'h0, 96'h0, 1'h1);
    cmd(vlan_pkg::CMD_RENAME, 4'h0, 3'h0, 1'h0, 96'h5A, 1'h0);
    cmd(vlan_pkg::CMD_DELETE, 4'h0, 3'h1, 1'h0, 96'h0, 1'h1);
    $display("config test done");
    for (int i = 0; i < 3; i++) frame(rows[i][0][3:0], rows[i][1], rows[i][2]);
    $display("row test done");
    cmd(vlan_pkg::CMD_SET_MAC, 4'h0, 3'h0, 1'h0, 96'h0, 1'h0);
    cmd(vlan_pkg::CMD_SET_MAC, 4'h0, 3'h1, 1'h0, 96'h0, 1'h0);
    for (int d = 0; d < 2; d++) begin
      @(posedge sys_clk_in);
      mac_sel_in <= 3'(d);
      @(posedge sys_clk_in);
      #1;
      chk(bpdu_src_mac_out, 48'hA000_0000_0000 + d);
      chk(ipx_node_out, 48'hA000_0000_0000 + d);
    end
    chk(dom_active_out, 8'h03);
    @(posedge sys_clk_in);
    link_up_in <= 16'hFF0F;
    @(posedge sys_clk_in);
    #1;
    chk(dom_active_out, 8'h01);
    @(posedge sys_clk_in);
    link_up_in <= 16'hFF8F;
    @(posedge sys_clk_in);
    #1;
    chk(dom_active_out, 8'h03);
    $display("status test done");
    cmd(vlan_pkg::CMD_MONITOR, 4'h0, 3'h0, 1'h1, 96'h0, 1'h0);
    frame(4'h1, 16'hFFFF, 16'hFF0C);
    frame(4'h0, 16'hFFFF, 16'h0000);
    cmd(vlan_pkg::CMD_ASSIGN, 4'h0, 3'h0, 1'h0, 96'h0, 1'h1);
    cmd(vlan_pkg::CMD_MONITOR, 4'h0, 3'h0, 1'h0, 96'h0, 1'h0);
    frame(4'h1, 16'hFFFF, 16'hFF0D);
    @(posedge sys_clk_in);
    slot_present_in <= 4'hD;
    @(posedge sys_clk_in);
    slot_present_in <= 4'hF;
    frame(4'h0, 16'hFFFF, 16'hFFFE);
    cmd(vlan_pkg::CMD_DELETE, 4'h0, 3'h1, 1'h0, 96'h0, 1'h0);
    $display("monitor and slot test done");
    // Full stall: ready must drop once the queue holds its depth
    @(posedge sys_clk_in);
    stall <= 1'h1;
    taken = 0;
    @(posedge sys_clk_in);
    frm_valid_in <= 1'h1;
    frm_in <= '{4'h1, 16'hFFFF, 8'h00};
    for (int i = 0; i < 14; i++) begin
      #1;
      taken += int'(frm_ready_out);
      @(posedge sys_clk_in);
    end
    frm_valid_in <= 1'h0;
    slow <= 1'h1;
    stall <= 1'h0;
    // Eight queued plus one parked in the output stage
    chk(48'(taken), 48'h9);
    repeat (40) @(posedge sys_clk_in);
    #1;
    chk({cnt, last.src_port, last.tag, last.dst_mask}, {8'(8'h07 + taken), 4'h1, 8'h00, 16'hFFFD});
    $display("buffer test done");
    cmd(vlan_pkg::CMD_CREATE, 4'h0, 3'h2, 1'h0, 96'h43, 1'h0);
    cmd(vlan_pkg::CMD_RESTART, 4'h0, 3'h0, 1'h0, 96'h0, 1'h0);
    cmd(vlan_pkg::CMD_MONITOR, 4'h3, 3'h0, 1'h1, 96'h0, 1'h0);
    chk({dom_usable_out, monitor_mask_out}, {8'h05, 16'h0008});
    // Mid-run reset must drop every configured change
    @(posedge sys_clk_in);
    sys_rst_in <= 1'h1;
    repeat (2) @(posedge sys_clk_in);
    sys_rst_in <= 1'h0;
    #1;
    chk({dom_usable_out, monitor_mask_out, frm_valid_out}, {8'h01, 16'h0000, 1'h0});
    frame(4'h3, 16'hFFFF, 16'hFFF7);
    $display("reset test done");
    report_and_stop();
  end
endmodule // tb_top
